// ---- verilog/ebra_bus_ctrl.v ----
`include "ebra_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// External bus controller with wait control and arbitration.
// ************************************************************
module ebra_bus_ctrl #(
    parameter ADDR_W = `EBRA_ADDR_W,
    parameter DATA_W = `EBRA_DATA_W,
    parameter LEN_W = `EBRA_ACC_LEN_W,
    parameter CORE_PERIOD_NS = `EBRA_CORE_PERIOD_NS,
    parameter REF_PERIOD_NS = `EBRA_REF_PERIOD_NS
) (
    // Clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // Configuration levels
    input wire [LEN_W-1:0] access_phase_length_in,
    input wire wait_enable_in,
    input wire wait_active_high_in,
    input wire wait_async_in,
    input wire arb_enable_in,
    // Request side
    input wire req_valid_in,
    input wire req_write_in,
    input wire req_upper_in,
    input wire [ADDR_W-1:0] req_addr_in,
    input wire [DATA_W-1:0] req_wdata_in,
    output reg req_accept_out,
    output reg req_done_out,
    output reg [DATA_W-1:0] rdata_out,
    // Bus pins
    input wire wait_ctrl_in,
    input wire [DATA_W-1:0] data_in,
    output reg [DATA_W-1:0] data_out,
    output reg data_oe_out,
    output reg [ADDR_W-1:0] addr_out,
    output reg addr_oe_out,
    output reg ale_out,
    output reg rd_n_out,
    output reg wr_n_out,
    output reg cs_n_out,
    output reg upper_byte_enable_n_out,
    output reg ctrl_oe_out,
    output reg reference_clock_out,
    // Arbitration pins
    input wire hold_n_in,
    output reg hold_acknowledge_n_out,
    output reg bus_request_n_out
);

    // ************************************************************
    // Reference clock divider
    // ************************************************************
    localparam integer HALF_CNT = (REF_PERIOD_NS / CORE_PERIOD_NS) / 2;
    // The count is worked out at full width and cut to the divider width on purpose.
    localparam [31:0] HALF_FULL = HALF_CNT - 1;
    localparam [7:0] HALF_LAST = HALF_FULL[7:0];

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_ACC = 3'd2;
    localparam [2:0] ST_WAIT = 3'd3;
    localparam [2:0] ST_REL = 3'd4;
    localparam [2:0] ST_HELD = 3'd5;
    localparam [2:0] ST_REGAIN = 3'd6;

    reg [7:0] div_q;
    wire half_end;
    wire unit_tick;

    assign half_end = (div_q == HALF_LAST);
    // Bus outputs other than the reference clock itself change only on the edge that raises the reference clock.
    assign unit_tick = half_end && !reference_clock_out;

    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q <= 8'h00;
            reference_clock_out <= 1'b0;
        end else if (half_end) begin
            div_q <= 8'h00;
            reference_clock_out <= !reference_clock_out;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    wire wait_s;
    wire hold_n_s;
    wire [DATA_W-1:0] data_s;

    ebra_sync #(.WIDTH(2), .RST_VAL(2'b10)) u_ctl_sync (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({hold_n_in, wait_ctrl_in}),
        .sync_out({hold_n_s, wait_s})
    );

    ebra_sync #(.WIDTH(DATA_W)) u_data_sync (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(data_in),
        .sync_out(data_s)
    );

    // ************************************************************
    // Wait-control qualification
    // ************************************************************
    function ready_level;
        input raw;
        input active_high;
        begin
            ready_level = active_high ? raw : !raw;
        end
    endfunction

    reg wait_stage_q;
    wire ready_now;
    wire ready_use;
    wire hold_req;

    assign ready_now = ready_level(wait_s, wait_active_high_in);
    // Asynchronous mode looks at the value held one unit earlier, which costs a unit.
    assign ready_use = wait_async_in ? wait_stage_q : ready_now;
    assign hold_req = arb_enable_in && !hold_n_s;

    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_stage_q <= 1'b0;
        end else if (unit_tick) begin
            wait_stage_q <= ready_now;
        end
    end

    // ************************************************************
    // Bus cycle and arbitration sequencer
    // ************************************************************
    reg [2:0] state_q;
    reg [LEN_W-1:0] cnt_q;
    reg write_q;

    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            cnt_q <= {LEN_W{1'b0}};
            write_q <= 1'b0;
            req_accept_out <= 1'b0;
            req_done_out <= 1'b0;
            rdata_out <= `EBRA_DATA_RST;
            data_out <= `EBRA_DATA_RST;
            data_oe_out <= 1'b0;
            addr_out <= `EBRA_ADDR_RST;
            addr_oe_out <= 1'b1;
            ale_out <= 1'b0;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            cs_n_out <= 1'b1;
            upper_byte_enable_n_out <= 1'b1;
            ctrl_oe_out <= 1'b1;
            hold_acknowledge_n_out <= 1'b1;
            bus_request_n_out <= 1'b1;
        end else begin
            req_accept_out <= 1'b0;
            req_done_out <= 1'b0;
            if (unit_tick) begin
                case (state_q)
                    ST_IDLE: begin
                        if (hold_req) begin
                            // No cycle is running here, so release may begin.
                            state_q <= ST_REL;
                            ale_out <= 1'b0;
                            rd_n_out <= 1'b1;
                            wr_n_out <= 1'b1;
                            cs_n_out <= 1'b1;
                            upper_byte_enable_n_out <= 1'b1;
                            data_oe_out <= 1'b0;
                        end else if (req_valid_in) begin
                            state_q <= ST_ADDR;
                            req_accept_out <= 1'b1;
                            write_q <= req_write_in;
                            addr_out <= req_addr_in;
                            data_out <= req_wdata_in;
                            data_oe_out <= req_write_in;
                            ale_out <= 1'b1;
                            cs_n_out <= 1'b0;
                            upper_byte_enable_n_out <= !req_upper_in;
                        end
                    end
                    ST_ADDR: begin
                        state_q <= ST_ACC;
                        ale_out <= 1'b0;
                        rd_n_out <= write_q;
                        wr_n_out <= !write_q;
                        cnt_q <= access_phase_length_in;
                    end
                    ST_ACC, ST_WAIT: begin
                        if (cnt_q != {LEN_W{1'b0}}) begin
                            cnt_q <= cnt_q - {{(LEN_W-1){1'b0}}, 1'b1};
                        end else if (wait_enable_in && !ready_use) begin
                            state_q <= ST_WAIT;
                        end else begin
                            // One edge raises the strobe, moves the address and takes the data.
                            state_q <= ST_IDLE;
                            req_done_out <= 1'b1;
                            rd_n_out <= 1'b1;
                            wr_n_out <= 1'b1;
                            cs_n_out <= 1'b1;
                            upper_byte_enable_n_out <= 1'b1;
                            data_oe_out <= 1'b0;
                            addr_out <= `EBRA_ADDR_RST;
                            if (!write_q) begin
                                rdata_out <= data_s;
                            end
                        end
                    end
                    ST_REL: begin
                        // Controls were driven inactive for a unit; now hand them to pull-ups.
                        state_q <= ST_HELD;
                        ctrl_oe_out <= 1'b0;
                        addr_oe_out <= 1'b0;
                        hold_acknowledge_n_out <= 1'b0;
                    end
                    ST_HELD: begin
                        if (!hold_req) begin
                            // The request may vanish without our asking, so regain on it alone.
                            state_q <= ST_REGAIN;
                            hold_acknowledge_n_out <= 1'b1;
                            bus_request_n_out <= 1'b1;
                        end else begin
                            bus_request_n_out <= !req_valid_in;
                        end
                    end
                    ST_REGAIN: begin
                        // Controls are driven inactive for two units before the next cycle.
                        state_q <= ST_IDLE;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
                if (state_q == ST_HELD && !hold_req) begin
                    ctrl_oe_out <= 1'b1;
                    addr_oe_out <= 1'b1;
                    ale_out <= 1'b0;
                end
            end
        end
    end

endmodule // ebra_bus_ctrl

`default_nettype wire

// ---- verilog/ebra_regs.vh ----
// Summary of operation
// - Access phase lasts one to thirty-two reference units, stretchable by the wait input.
// - Read data is captured on the edge that raises the read strobe.
// - A configuration input selects active-high or active-low wait input.
// - Asynchronous mode adds a synchroniser stage and one unit to cycles that the wait input ends.
// - Inactive wait input at a sample inserts a wait state; active ends cycle.
// - Sample points differ between synchronous and asynchronous wait modes.
// - With arbitration enabled, a hold request makes the controller release the bus.
// - A running bus cycle completes before the bus is handed over.
// - On release, controls are driven inactive, then released to pull-ups, latch enable low.
// - Regain starts only when the hold request goes away.
// - On regain, controls go from pull-up to driven inactive before the next cycle.
`ifndef EBRA_REGS_VH
`define EBRA_REGS_VH

// ************************************************************
// Timing
// ************************************************************
`define EBRA_CORE_PERIOD_NS 20
`define EBRA_REF_PERIOD_NS 160

// ************************************************************
// Field widths and reset values
// ************************************************************
`define EBRA_ACC_LEN_W 5
`define EBRA_ADDR_W 24
`define EBRA_DATA_W 16
`define EBRA_ADDR_RST 24'h00_0000
`define EBRA_DATA_RST 16'h0000

`endif

// ---- verilog/ebra_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Two flip-flop synchroniser for pin inputs.
// ************************************************************
module ebra_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // ebra_sync

`default_nettype wire

// ---- dv/ebra_bus_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Port checker for the bus controller.
// ************************************************************
module ebra_bus_monitor #(
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Watched pins
    input wire logic hold_n_in,
    input wire logic req_accept_out,
    input wire logic req_done_out,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic data_oe_out,
    input wire logic addr_oe_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic cs_n_out,
    input wire logic ctrl_oe_out,
    input wire logic reference_clock_out,
    input wire logic hold_acknowledge_n_out,
    input wire logic bus_request_n_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    start_on_tick_a: assert property (req_accept_out |-> $rose(reference_clock_out) && ale_out && !cs_n_out)
        else $error("cycle started off a unit tick");
    unit_period_a: assert property ($rose(reference_clock_out) |-> ##8 $rose(reference_clock_out))
        else $error("reference clock period wrong");
    strobe_end_a: assert property ($rose(rd_n_out) || $rose(wr_n_out) |-> req_done_out && $rose(cs_n_out))
        else $error("strobe ended without cycle end");
    read_latch_a: assert property (!(req_done_out && !$past(rd_n_out)) |-> $stable(rdata_out))
        else $error("read data moved outside a read end");
    cycle_first_a: assert property (!cs_n_out |-> hold_acknowledge_n_out && ctrl_oe_out)
        else $error("bus handed over mid cycle");
    release_order_a: assert property ($fell(hold_acknowledge_n_out) |-> !ctrl_oe_out && !addr_oe_out
        && $past(ctrl_oe_out) && $past(rd_n_out) && $past(wr_n_out) && $past(cs_n_out) && !ale_out)
        else $error("controls not driven inactive before release");
    held_quiet_a: assert property (!hold_acknowledge_n_out |-> !ctrl_oe_out && !data_oe_out && !ale_out)
        else $error("bus driven while acknowledged");
    hold_keeps_a: assert property (!hold_n_in [*3] ##0 !hold_acknowledge_n_out |=> !hold_acknowledge_n_out)
        else $error("regain while hold still requested");
    request_held_a: assert property (!bus_request_n_out |-> !hold_acknowledge_n_out)
        else $error("bus request outside hold");
    regain_order_a: assert property ($rose(hold_acknowledge_n_out) |-> ctrl_oe_out && addr_oe_out && rd_n_out
        && !ale_out ##1 !req_accept_out [*8])
        else $error("regain sequence wrong");
endmodule // ebra_bus_monitor

bind ebra_bus_ctrl ebra_bus_monitor #(.DATA_W(DATA_W)) u_mon (.*);

`default_nettype wire

// ---- dv/ebra_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// External memory with a ready output.
// ************************************************************
module ebra_mem_model (
    // Bus pins
    input wire logic core_clk_in,
    input wire logic reference_clock_out,
    input wire logic [23:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic data_oe_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic cs_n_out,
    input wire logic wait_active_high_in,
    input wire logic [3:0] delay_in,
    // Driven back
    output logic [15:0] data_in,
    output logic wait_ctrl_in
);
    logic [15:0] mem [int];
    logic ready;
    int cnt;
    initial begin
        data_in = 16'h0000;
        ready = 1'b0;
        cnt = 0;
    end
    // Off a read the lines toggle every cycle, so stale data never looks valid.
    always @(posedge core_clk_in) begin
        if (!wr_n_out && !cs_n_out && data_oe_out)
            mem[addr_out] = data_out;
        data_in <= (!rd_n_out && !cs_n_out) ? (mem.exists(addr_out) ? mem[addr_out] : addr_out[15:0] ^ 16'hc3a5)
            : ~data_in;
    end
    always @(negedge reference_clock_out) begin
        if (rd_n_out && wr_n_out) begin
            cnt = 0;
            ready = 1'b0;
        end else begin
            ready = cnt >= delay_in;
            cnt = cnt + 1;
        end
    end
    assign wait_ctrl_in = ready ~^ wait_active_high_in;
endmodule // ebra_mem_model

`default_nettype wire

// ---- dv/external_bus_ready_arbitration_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Bench for the external bus controller.
// ************************************************************
module external_bus_ready_arbitration_bench;
    logic core_clk_in = 0, reset_n_in = 0, req_valid_in = 0, req_write_in = 0, req_upper_in = 0, hold_n_in = 1;
    logic wait_enable_in = 0, wait_active_high_in = 1, wait_async_in = 0, arb_enable_in = 1;
    logic [4:0] access_phase_length_in = 0;
    logic [3:0] delay_in = 0;
    logic [23:0] req_addr_in = 0, addr_out, a;
    logic [15:0] req_wdata_in = 0, rdata_out, data_in, data_out;
    logic req_accept_out, req_done_out, data_oe_out, addr_oe_out, ale_out, rd_n_out, wr_n_out, cs_n_out;
    logic upper_byte_enable_n_out, ctrl_oe_out, reference_clock_out, hold_acknowledge_n_out;
    logic bus_request_n_out, wait_ctrl_in;
    logic [15:0] exp_mem [int];
    int miscompares = 0, checks_done = 0, n, acc_wait;
    ebra_bus_ctrl dut (.*);
    ebra_mem_model u_mem (.*);
    initial forever #10 core_clk_in = ~core_clk_in;
    task automatic step(input int k);
        repeat (k) @(posedge core_clk_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One whole bus cycle; the task works out its expected length in units.
    task automatic xfer(input logic wr, input logic [23:0] ad, input logic [15:0] d, input logic [4:0] len,
        input int dl);
        int u;
        access_phase_length_in = len;
        delay_in = 4'(dl);
        {req_write_in, req_addr_in, req_wdata_in, req_upper_in} = {wr, ad, d, ad[0]};
        req_valid_in = 1;
        acc_wait = 0;
        do begin step(1); acc_wait++; end while (req_accept_out !== 1'b1 && acc_wait < 400);
        req_valid_in = 0;
        chk("pins", {ale_out, cs_n_out, upper_byte_enable_n_out, addr_out}, {2'b10, ~ad[0], ad});
        n = 0;
        do begin step(1); n++; end while (req_done_out !== 1'b1 && n < 400);
        u = len + 2;
        if (wait_enable_in && dl + 2 + wait_async_in > u)
            u = dl + 2 + wait_async_in;
        chk("cycle length", n, u * 8);
        if (wr)
            exp_mem[ad] = d;
        else
            chk("read data", rdata_out, exp_mem.exists(ad) ? exp_mem[ad] : ad[15:0] ^ 16'hc3a5);
    endtask
    initial begin
        #400_000;
        miscompares++;
        results();
    end
    initial begin
        void'($urandom(18669));
        step(20);
        reset_n_in = 1;
        // Every wait mode and polarity, write then read back.
        for (int m = 0; m < 8; m++) begin
            {wait_enable_in, wait_async_in, wait_active_high_in} = 3'(m);
            a = 24'($urandom);
            xfer(1, a, 16'($urandom), 5'($urandom % 4), $urandom % 3);
            xfer(0, a, 16'h0000, 5'($urandom % 4), $urandom % 3);
            $display("wait mode %0d done", m);
        end
        xfer(0, 24'h00_0010, 16'h0000, 5'h1f, 0);
        wait_async_in = 0;
        xfer(0, 24'h00_0011, 16'h0000, 5'h00, 5);
        $display("length bounds done");
        fork
            xfer(0, 24'h00_0100, 16'h0000, 5'h03, 0);
            begin @(posedge req_accept_out); #1; hold_n_in = 0; end
        join
        chk("acknowledge at cycle end", hold_acknowledge_n_out, 1);
        fork
            xfer(0, 24'h00_0101, 16'h0000, 5'h00, 0);
            begin
                step(80);
                chk("released", {hold_acknowledge_n_out, bus_request_n_out, ctrl_oe_out, addr_oe_out}, 0);
                hold_n_in = 1;
            end
        join
        chk("refused while held", acc_wait > 80, 1);
        $display("hold in cycle done");
        hold_n_in = 0;
        step(40);
        chk("idle release", {hold_acknowledge_n_out, bus_request_n_out}, 2'b01);
        hold_n_in = 1;
        step(40);
        chk("idle regain", {hold_acknowledge_n_out, ctrl_oe_out, ale_out}, 3'b110);
        arb_enable_in = 0;
        hold_n_in = 0;
        xfer(0, 24'h00_0200, 16'h0000, 5'h01, 0);
        chk("no arbitration", hold_acknowledge_n_out, 1);
        $display("hold tests done");
        results();
    end
endmodule // external_bus_ready_arbitration_bench

`default_nettype wire
